//--- rtl/atro_axis_trim.v
// Purpose: one axis of offset and gain trim, with the offset adder
// Assumes: write strobes and data come from logic on sys_clk_i
// Notes:   offset is 15-bit two's complement, gain 9-bit unsigned
`timescale 1ns/1ps
`include "atro_defs.vh"

module atro_axis_trim #(
    parameter DW = 16
) (
    input  wire          sys_clk_i,
    input  wire          rst_b_i,
    input  wire          wr_lo_i,
    input  wire          wr_hi_i,
    input  wire          wr_gain_i,
    input  wire [7:0]    wdata_i,
    input  wire [DW-1:0] acc_i,
    input  wire          acc_vld_i,
    output reg  [DW-1:0] acc_o,
    output reg           acc_vld_o,
    output wire [7:0]    lo_o,
    output wire [7:0]    hi_o,
    output wire [7:0]    gain_lo_o,
    output wire [8:0]    gain_o
);

    reg  [14:0]   offs_q;
    reg  [8:0]    gain_q;
    wire [DW-1:0] offs_ext;

    // ****************************************************************
    // trim storage; high byte carries gain bit 8 in bit 7
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            offs_q <= `ATRO_RST_OFFS;
            gain_q <= `ATRO_RST_GAIN;
        end else begin
            if (wr_lo_i) begin
                offs_q[7:0] <= wdata_i;
            end
            if (wr_hi_i) begin
                offs_q[14:8] <= wdata_i[6:0];
                gain_q[8]    <= wdata_i[`ATRO_B_GAIN_MSB];
            end
            if (wr_gain_i) begin
                gain_q[7:0] <= wdata_i;
            end
        end
    end

    // sign extend the 15-bit offset to the sample width
    assign offs_ext = {{(DW-15){offs_q[14]}}, offs_q};

    // ****************************************************************
    // offset applied before the sample reaches the output registers
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            acc_o     <= {DW{1'b0}};
            acc_vld_o <= 1'b0;
        end else begin
            acc_vld_o <= acc_vld_i;
            if (acc_vld_i) begin
                acc_o <= acc_i + offs_ext;
            end
        end
    end

    // read-back views for read-modify-write by the host
    assign lo_o      = offs_q[7:0];
    assign hi_o      = {gain_q[8], offs_q[14:8]};
    assign gain_lo_o = gain_q[7:0];
    assign gain_o    = gain_q;

endmodule

//--- rtl/atro_defs.vh
// Purpose: shared constants of the accelerometer trim and reset register group
// Assumes: 8-bit register bus from the serial engine, 25 MHz system clock
// Notes:   definitions only
`ifndef ATRO_DEFS_VH
`define ATRO_DEFS_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define ATRO_A_ZDRIVE      8'h22
`define ATRO_A_SRST        8'h24
`define ATRO_A_SETUP2      8'h28
`define ATRO_A_ONESHOT_SAMPLE_COUNT       8'h29
`define ATRO_A_X_OFFSET_LOW       8'h2a
`define ATRO_A_X_OFFSET_HIGH_GAIN_MSB       8'h2b
`define ATRO_A_Y_OFFSET_LOW       8'h2c
`define ATRO_A_Y_OFFSET_HIGH_GAIN_MSB       8'h2d
`define ATRO_A_Z_OFFSET_LOW       8'h2e
`define ATRO_A_Z_OFFSET_HIGH_GAIN_MSB       8'h2f
`define ATRO_A_X_AXIS_GAIN       8'h30
`define ATRO_A_Y_AXIS_GAIN       8'h31
`define ATRO_A_Z_AXIS_GAIN       8'h32

// ****************************************************************
// field positions
// ****************************************************************
`define ATRO_B_DRV_POS     2
`define ATRO_B_DRV_NEG     3
`define ATRO_B_SOFT_RST    6
`define ATRO_B_RELOAD      7
`define ATRO_B_GAIN_MSB    7

// ****************************************************************
// reset values and counts
// ****************************************************************
`define ATRO_RST_BYTE      8'h00
`define ATRO_RST_OFFS      15'h0000
`define ATRO_RST_GAIN      9'h000
`define ATRO_TRIG_NONE     8'h00
`define ATRO_TRIG_CONT     8'hff
`define ATRO_OTP_WORDS     4'h9
`define ATRO_OTP_FIELDS    2'h3
`define ATRO_SRST_NS       200
`define ATRO_CLK_NS        40

`endif

//--- rtl/atro_regs.v
// Purpose: z test drive, soft reset, nonvolatile reload, trigger count and
//          per-axis offset/gain trim registers of the accelerometer
// Assumes: all inputs come from logic on sys_clk_i (serial engine, otp macro)
// Notes:   otp read data is valid one clock after otp_rd_o
//
// How it works
// - z drive bit 2 pushes positive, bit 3 negative, both reset off
// - any reset returns the serial port from three-wire to four-wire
// - bit 6 of reset register runs full reset: defaults, then reload
// - soft reset request bit clears itself when the sequence ends
// - bit 7 reload: enable otp, copy all words, disable otp
// - busy flag shows while reload runs; host polls it
// - reload request bit stays set until host writes it zero or a soft reset runs
// - trigger count 1..254 sets samples captured after one-shot start
// - count 255 samples continuously until operating mode changes
// - each axis adds signed 15-bit offset before output registers
// - offsets come out of reset with factory values; host may overwrite
// - offset low byte bits 7..0, high byte 14..8 plus gain bit 8
// - gain is 9-bit unsigned, low byte at 0x30 onwards
`timescale 1ns/1ps
`include "atro_defs.vh"

module atro_regs #(
    parameter DW = 16
) (
    input  wire            sys_clk_i,
    input  wire            rst_b_i,
    // register access from the serial engine
    input  wire [7:0]      reg_addr_i,
    input  wire [7:0]      reg_wdata_i,
    input  wire            reg_wr_i,
    input  wire            reg_rd_i,
    output reg  [7:0]      reg_rdata_o,
    // nonvolatile memory macro
    output reg             otp_en_o,
    output reg             otp_rd_o,
    output reg  [3:0]      otp_addr_o,
    input  wire [7:0]      otp_rdata_i,
    output wire            otp_busy_o,
    // reset of the rest of the device and serial port mode
    output wire            soft_reset_o,
    input  wire            spi_3wire_set_i,
    output reg             spi_three_wire_o,
    // test drive and setup
    output wire            z_drive_positive_o,
    output wire            z_drive_negative_o,
    output reg  [7:0]      fixed_setup_two_o,
    // one-shot sampling
    output reg  [7:0]      oneshot_sample_count_o,
    input  wire            trig_start_i,
    input  wire            trig_sample_i,
    input  wire            mode_change_i,
    output reg             trig_active_o,
    // samples in and trimmed samples out, x in low bits
    input  wire [3*DW-1:0] acc_i,
    input  wire            acc_vld_i,
    output wire [3*DW-1:0] acc_o,
    output wire            acc_vld_o,
    output wire [26:0]     gain_o
);

    // ****************************************************************
    // sequencer states and timing
    // ****************************************************************
    localparam [2:0] S_IDLE = 3'd0;
    localparam [2:0] S_SRST = 3'd1;
    localparam [2:0] S_ON   = 3'd2;
    localparam [2:0] S_READ = 3'd3;
    localparam [2:0] S_CAPT = 3'd4;
    localparam [2:0] S_OFF  = 3'd5;

    // least time the device-wide reset pulse stands, rounded up
    localparam integer SRST_CYC_I = (`ATRO_SRST_NS + `ATRO_CLK_NS - 1) / `ATRO_CLK_NS;
    localparam [3:0]   SRST_CYC   = SRST_CYC_I[3:0];

    reg  [2:0]        state_q;
    reg  [2:0]        state_d;
    reg  [3:0]        tmr_q;
    reg  [3:0]        tmr_d;
    reg  [3:0]        word_q;
    reg  [3:0]        word_d;
    reg  [1:0]        ax_q;
    reg  [1:0]        ax_d;
    reg  [1:0]        fld_q;
    reg  [1:0]        fld_d;
    reg               seq_soft_q;
    reg               seq_soft_d;
    reg               srst_bit_q;
    reg               reload_bit_q;
    reg  [1:0]        zdrv_q;
    reg  [7:0]        trig_cnt_q;
    reg               start_soft;
    reg               start_reload;
    reg               seq_done;
    wire              wr_srst;
    wire              in_seq;
    wire              in_srst;
    wire              dflt_clr;
    wire [7:0]        lo_rd [0:2];
    wire [7:0]        hi_rd [0:2];
    wire [7:0]        gl_rd [0:2];
    reg  [2:0]        wr_lo;
    reg  [2:0]        wr_hi;
    reg  [2:0]        wr_gain;
    reg  [7:0]        trim_wdata;

    assign wr_srst = reg_wr_i && (reg_addr_i == `ATRO_A_SRST);
    assign in_seq  = (state_q != S_IDLE);
    assign in_srst = (state_q == S_SRST);
    assign dflt_clr = start_soft || in_srst;

    // ****************************************************************
    // reset and reload sequencer
    // ****************************************************************
    // request decode; soft reset outranks reload if both set at once
    always @* begin
        start_soft   = 1'b0;
        start_reload = 1'b0;
        if (wr_srst && !in_seq) begin
            start_soft   = reg_wdata_i[`ATRO_B_SOFT_RST];
            // only a rising reload bit starts work, a held one does not repeat
            start_reload = reg_wdata_i[`ATRO_B_RELOAD] && !reload_bit_q
                           && !reg_wdata_i[`ATRO_B_SOFT_RST];
        end
    end

    // next state
    always @* begin
        state_d    = state_q;
        tmr_d      = tmr_q;
        word_d     = word_q;
        ax_d       = ax_q;
        fld_d      = fld_q;
        seq_soft_d = seq_soft_q;
        seq_done   = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (start_soft) begin
                    state_d    = S_SRST;
                    tmr_d      = SRST_CYC;
                    seq_soft_d = 1'b1;
                end else if (start_reload) begin
                    state_d    = S_ON;
                    seq_soft_d = 1'b0;
                end
            end
            S_SRST: begin
                // other registers held at defaults, then stored data is restored
                tmr_d = tmr_q - 4'h1;
                if (tmr_q == 4'h1) begin
                    state_d = S_ON;
                end
            end
            S_ON: begin
                // core enabled one cycle before the first read
                word_d  = 4'h0;
                ax_d    = 2'h0;
                fld_d   = 2'h0;
                state_d = S_READ;
            end
            S_READ: begin
                state_d = S_CAPT;
            end
            S_CAPT: begin
                word_d = word_q + 4'h1;
                if (fld_q == `ATRO_OTP_FIELDS - 2'h1) begin
                    fld_d = 2'h0;
                    ax_d  = ax_q + 2'h1;
                end else begin
                    fld_d = fld_q + 2'h1;
                end
                if (word_q == `ATRO_OTP_WORDS - 4'h1) begin
                    state_d = S_OFF;
                end else begin
                    state_d = S_READ;
                end
            end
            S_OFF: begin
                seq_done = 1'b1;
                state_d  = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // sequencer flops; power-on starts with a factory-value load
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q    <= S_ON;
            tmr_q      <= 4'h0;
            word_q     <= 4'h0;
            ax_q       <= 2'h0;
            fld_q      <= 2'h0;
            seq_soft_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            tmr_q      <= tmr_d;
            word_q     <= word_d;
            ax_q       <= ax_d;
            fld_q      <= fld_d;
            seq_soft_q <= seq_soft_d;
        end
    end

    // otp macro controls, registered so the macro sees clean levels
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            otp_en_o   <= 1'b1; // load runs at once
            otp_rd_o   <= 1'b0;
            otp_addr_o <= 4'h0;
        end else begin
            otp_en_o   <= (state_d == S_ON) || (state_d == S_READ)
                          || (state_d == S_CAPT);
            otp_rd_o   <= (state_d == S_READ);
            otp_addr_o <= word_d;
        end
    end

    // busy also covers the soft reset so pollers never see a half load
    assign otp_busy_o   = in_seq;
    assign soft_reset_o = in_srst;

    // ****************************************************************
    // reset register bits
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            srst_bit_q   <= 1'b0;
            reload_bit_q <= 1'b0;
        end else begin
            if (start_soft) begin
                srst_bit_q <= 1'b1;
            end else if (seq_done && seq_soft_q) begin
                srst_bit_q <= 1'b0;
            end
            if (dflt_clr) begin
                reload_bit_q <= 1'b0;
            end else if (wr_srst && !start_soft) begin
                reload_bit_q <= reg_wdata_i[`ATRO_B_RELOAD];
            end
        end
    end

    // ****************************************************************
    // serial port wire mode
    // ****************************************************************
    // reset wins over a set arriving in the same cycle
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            spi_three_wire_o <= 1'b0;
        end else if (dflt_clr) begin
            spi_three_wire_o <= 1'b0;
        end else if (spi_3wire_set_i) begin
            spi_three_wire_o <= 1'b1;
        end
    end

    // ****************************************************************
    // plain control registers
    // ****************************************************************
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            zdrv_q                 <= 2'b00;
            fixed_setup_two_o      <= `ATRO_RST_BYTE;
            oneshot_sample_count_o <= `ATRO_RST_BYTE;
        end else if (dflt_clr) begin
            zdrv_q                 <= 2'b00;
            fixed_setup_two_o      <= `ATRO_RST_BYTE;
            oneshot_sample_count_o <= `ATRO_RST_BYTE;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ATRO_A_ZDRIVE) begin
                // reserved bits are not stored; host keeps them zero
                zdrv_q <= reg_wdata_i[`ATRO_B_DRV_NEG:`ATRO_B_DRV_POS];
            end else if (reg_addr_i == `ATRO_A_SETUP2) begin
                fixed_setup_two_o <= reg_wdata_i;
            end else if (reg_addr_i == `ATRO_A_ONESHOT_SAMPLE_COUNT) begin
                oneshot_sample_count_o <= reg_wdata_i;
            end
        end
    end

    // both directions passed as written; the host keeps them exclusive
    assign z_drive_positive_o = zdrv_q[0];
    assign z_drive_negative_o = zdrv_q[1];

    // ****************************************************************
    // one-shot sample counter
    // ****************************************************************
    // a count of zero captures nothing
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trig_active_o <= 1'b0;
            trig_cnt_q    <= 8'h00;
        end else if (dflt_clr || mode_change_i) begin
            trig_active_o <= 1'b0;
            trig_cnt_q    <= 8'h00;
        end else if (trig_start_i) begin
            trig_active_o <= (oneshot_sample_count_o != `ATRO_TRIG_NONE);
            trig_cnt_q    <= 8'h00;
        end else if (trig_active_o && trig_sample_i) begin
            // continuous mode never reaches the stop compare
            if (oneshot_sample_count_o != `ATRO_TRIG_CONT) begin
                trig_cnt_q <= trig_cnt_q + 8'h01;
                if (trig_cnt_q + 8'h01 == oneshot_sample_count_o) begin
                    trig_active_o <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // trim write steering
    // ****************************************************************
    // the loader owns the trim bytes while it runs; host writes then drop
    always @* begin
        wr_lo      = 3'b000;
        wr_hi      = 3'b000;
        wr_gain    = 3'b000;
        trim_wdata = reg_wdata_i;
        if (state_q == S_CAPT) begin
            trim_wdata = otp_rdata_i;
            if (fld_q == 2'h0) begin
                wr_lo[ax_q] = 1'b1;
            end else if (fld_q == 2'h1) begin
                wr_hi[ax_q] = 1'b1;
            end else begin
                wr_gain[ax_q] = 1'b1;
            end
        end else if (reg_wr_i && !in_seq) begin
            if (reg_addr_i == `ATRO_A_X_OFFSET_LOW) begin
                wr_lo[0] = 1'b1;
            end else if (reg_addr_i == `ATRO_A_X_OFFSET_HIGH_GAIN_MSB) begin
                wr_hi[0] = 1'b1;
            end else if (reg_addr_i == `ATRO_A_Y_OFFSET_LOW) begin
                wr_lo[1] = 1'b1;
            end else if (reg_addr_i == `ATRO_A_Y_OFFSET_HIGH_GAIN_MSB) begin
                wr_hi[1] = 1'b1;
            end else if (reg_addr_i == `ATRO_A_Z_OFFSET_LOW) begin
                wr_lo[2] = 1'b1;
            end else if (reg_addr_i == `ATRO_A_Z_OFFSET_HIGH_GAIN_MSB) begin
                wr_hi[2] = 1'b1;
            end else if (reg_addr_i == `ATRO_A_X_AXIS_GAIN) begin
                wr_gain[0] = 1'b1;
            end else if (reg_addr_i == `ATRO_A_Y_AXIS_GAIN) begin
                wr_gain[1] = 1'b1;
            end else if (reg_addr_i == `ATRO_A_Z_AXIS_GAIN) begin
                wr_gain[2] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // per-axis trim
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_axis
            wire vld_unused;
            atro_axis_trim #(
                .DW(DW)
            ) u_trim (
                .sys_clk_i (sys_clk_i),
                .rst_b_i   (rst_b_i),
                .wr_lo_i   (wr_lo[g]),
                .wr_hi_i   (wr_hi[g]),
                .wr_gain_i (wr_gain[g]),
                .wdata_i   (trim_wdata),
                .acc_i     (acc_i[g*DW +: DW]),
                .acc_vld_i (acc_vld_i),
                .acc_o     (acc_o[g*DW +: DW]),
                .acc_vld_o (vld_unused),
                .lo_o      (lo_rd[g]),
                .hi_o      (hi_rd[g]),
                .gain_lo_o (gl_rd[g]),
                .gain_o    (gain_o[g*9 +: 9])
            );
            if (g == 0) begin : g_vld
                assign acc_vld_o = vld_unused;
            end
        end
    endgenerate

    // ****************************************************************
    // read data
    // ****************************************************************
    // held between reads; unmapped addresses answer zero
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= `ATRO_RST_BYTE;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `ATRO_A_ZDRIVE) begin
                reg_rdata_o <= {4'h0, zdrv_q, 2'b00};
            end else if (reg_addr_i == `ATRO_A_SRST) begin
                reg_rdata_o <= {reload_bit_q, srst_bit_q, 6'h00};
            end else if (reg_addr_i == `ATRO_A_SETUP2) begin
                reg_rdata_o <= fixed_setup_two_o;
            end else if (reg_addr_i == `ATRO_A_ONESHOT_SAMPLE_COUNT) begin
                reg_rdata_o <= oneshot_sample_count_o;
            end else if (reg_addr_i == `ATRO_A_X_OFFSET_LOW) begin
                reg_rdata_o <= lo_rd[0];
            end else if (reg_addr_i == `ATRO_A_X_OFFSET_HIGH_GAIN_MSB) begin
                reg_rdata_o <= hi_rd[0];
            end else if (reg_addr_i == `ATRO_A_Y_OFFSET_LOW) begin
                reg_rdata_o <= lo_rd[1];
            end else if (reg_addr_i == `ATRO_A_Y_OFFSET_HIGH_GAIN_MSB) begin
                reg_rdata_o <= hi_rd[1];
            end else if (reg_addr_i == `ATRO_A_Z_OFFSET_LOW) begin
                reg_rdata_o <= lo_rd[2];
            end else if (reg_addr_i == `ATRO_A_Z_OFFSET_HIGH_GAIN_MSB) begin
                reg_rdata_o <= hi_rd[2];
            end else if (reg_addr_i == `ATRO_A_X_AXIS_GAIN) begin
                reg_rdata_o <= gl_rd[0];
            end else if (reg_addr_i == `ATRO_A_Y_AXIS_GAIN) begin
                reg_rdata_o <= gl_rd[1];
            end else if (reg_addr_i == `ATRO_A_Z_AXIS_GAIN) begin
                reg_rdata_o <= gl_rd[2];
            end else begin
                reg_rdata_o <= `ATRO_RST_BYTE;
            end
        end
    end

endmodule

//--- verif/atro_otp_model.sv
// Purpose: nonvolatile memory macro behind the register block
// Assumes: data wanted one clock after an enabled read strobe
// Notes:   content pattern is arbitrary, stands for per-part trim
`timescale 1ns/1ps
module atro_otp_model (
    input  wire        sys_clk_i,
    input  wire        otp_en_o,
    input  wire        otp_rd_o,
    input  wire  [3:0] otp_addr_o,
    output logic [7:0] otp_rdata_i = 8'h00
);
    // calibration word per address, value arbitrary
    function automatic logic [7:0] ow(input logic [3:0] a);
        ow = 8'ha7 ^ {a, ~a};
    endfunction
    // toggles when idle so stale data can never pass for a fresh word
    always @(posedge sys_clk_i) begin
        if (otp_en_o && otp_rd_o)
            otp_rdata_i <= ow(otp_addr_o);
        else
            otp_rdata_i <= ~otp_rdata_i;
    end
endmodule

//--- verif/atro_regs_sva.sv
// Purpose: port-level checks on the trim and reset register block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to the top module from the bench
`timescale 1ns/1ps
module atro_regs_sva #(
    parameter DW = 16
) (
    input wire       sys_clk_i,
    input wire       rst_b_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire       reg_wr_i,
    input wire       otp_en_o,
    input wire       otp_rd_o,
    input wire       otp_busy_o,
    input wire       soft_reset_o,
    input wire       spi_three_wire_o,
    input wire       z_drive_positive_o,
    input wire       z_drive_negative_o
);
    // one domain, so clock and reset are given once
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_pulse; soft_reset_o [*5] ##1 !soft_reset_o; endsequence
    sequence s_load; otp_busy_o && !otp_rd_o ##1 otp_rd_o; endsequence
    property p_zdrv; reg_wr_i && reg_addr_i == 8'h22 && !soft_reset_o |=>
        {z_drive_negative_o, z_drive_positive_o} == $past(reg_wdata_i[3:2]); endproperty
    a_zdrv: assert property (p_zdrv) else $error("z drive mismatch");
    property p_srst; reg_wr_i && reg_addr_i == 8'h24 && reg_wdata_i[6] && !otp_busy_o |=> s_pulse; endproperty
    a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
    property p_swire; soft_reset_o |-> !spi_three_wire_o; endproperty
    a_swire: assert property (p_swire) else $error("three-wire kept in reset");
    property p_dflt; soft_reset_o |-> !z_drive_positive_o && !z_drive_negative_o; endproperty
    a_dflt: assert property (p_dflt) else $error("drive kept in reset");
    property p_on; $rose(otp_en_o) |-> s_load; endproperty
    a_on: assert property (p_on) else $error("enable not followed by read");
    property p_rdok; otp_rd_o |-> otp_en_o && otp_busy_o; endproperty
    a_rdok: assert property (p_rdok) else $error("read while idle");
    property p_rdpls; otp_rd_o |=> !otp_rd_o; endproperty
    a_rdpls: assert property (p_rdpls) else $error("read strobe too long");
    property p_after; $fell(soft_reset_o) |-> otp_busy_o; endproperty
    a_after: assert property (p_after) else $error("no reload after reset");
endmodule

//--- verif/atro_regs_tb.sv
// Purpose: self-checking bench for the trim and reset register block
// Assumes: bench plays a well-behaved host; memory macro modelled
// Notes:   random data from a fixed seed plus boundary counts
`timescale 1ns/1ps
module atro_regs_tb;
    logic        sys_clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, acc_vld_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, otp_rdata_i, q, lo, hi, g;
    logic [7:0]  fixed_setup_two_o, oneshot_sample_count_o;
    logic [3:0]  ev = 4'h0, otp_addr_o;
    logic [47:0] acc_i = 48'h0, acc_o;
    logic [26:0] gain_o;
    logic [15:0] raw;
    logic        otp_en_o, otp_rd_o, otp_busy_o, soft_reset_o, spi_three_wire_o, trig_active_o, acc_vld_o;
    logic        z_drive_positive_o, z_drive_negative_o;
    int          error_cnt = 0, cmp_count = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    atro_regs #(.DW(16)) i_dut(.*, .spi_3wire_set_i(ev[3]), .trig_start_i(ev[0]), .trig_sample_i(ev[1]),
        .mode_change_i(ev[2]));
    atro_otp_model i_otp(.*);
    // ****************************************************************
    // host tasks
    // ****************************************************************
    task automatic chk(input logic [47:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge sys_clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    // data lands one clock after the strobe edge
    task automatic rd(input logic [7:0] a, exp);
        @(posedge sys_clk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask
    // one-clock pulse on the event inputs
    task automatic pu(input logic [3:0] m);
        @(posedge sys_clk_i);
        ev <= m;
        @(posedge sys_clk_i);
        ev <= 4'h0;
        #1;
    endtask
    // bounded busy wait
    task automatic wb;
        int n = 0;
        #1;
        while (otp_busy_o !== 1'b0 && n < 100) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        if (n == 100)
            chk(48'h1, 48'h0);
    endtask
    task summarize;
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        error_cnt++;
        summarize;
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        logic [7:0] ra[5] = '{8'h22, 8'h24, 8'h28, 8'h29, 8'h40};
        logic [7:0] tc[3] = '{8'h01, 8'h05, 8'hfe};
        void'($urandom(32'h91c2));
        repeat (12) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        wb;
        wr(8'h28, 8'h00);
        foreach (ra[i]) rd(ra[i], 8'h00);
        for (int k = 0; k < 9; k++) rd(8'((k % 3 == 2) ? 8'h30 + k / 3 : 8'h2a + k / 3 * 2 + k % 3), i_otp.ow(4'(k)));
        repeat (6) begin
            q = 8'($urandom_range(2)) << 2; // one direction at most, reserved bits zero
            wr(8'h22, q);
            chk({z_drive_negative_o, z_drive_positive_o}, q[3:2]);
        end
        for (int k = 0; k < 3; k++) begin
            {lo, hi, g, raw} = 40'({$urandom, $urandom});
            wr(8'(8'h2a + 2 * k), lo);
            wr(8'(8'h2b + 2 * k), hi);
            wr(8'(8'h30 + k), g);
            @(posedge sys_clk_i);
            {acc_i, acc_vld_i} <= {{3{raw}}, 1'b1};
            @(posedge sys_clk_i);
            acc_vld_i <= 1'b0;
            #1 chk(acc_o[k * 16 +: 16], 16'(raw + {hi[6], hi[6:0], lo}));
            chk({acc_vld_o, gain_o[k * 9 +: 9]}, {1'b1, hi[7], g});
            rd(8'(8'h2b + 2 * k), hi);
        end
        foreach (tc[i]) begin
            wr(8'h29, tc[i]);
            pu(4'h1);
            repeat (tc[i] - 1) pu(4'h2);
            chk({fixed_setup_two_o, oneshot_sample_count_o, trig_active_o}, {8'h00, tc[i], 1'b1});
            pu(4'h2);
            @(posedge sys_clk_i);
            #1 chk(trig_active_o, 1'b0);
        end
        wr(8'h29, 8'hff);
        pu(4'h1);
        repeat (260) pu(4'h2);
        chk(trig_active_o, 1'b1);
        pu(4'h4);
        @(posedge sys_clk_i);
        #1 chk(trig_active_o, 1'b0);
        wr(8'h2a, ~i_otp.ow(4'h0));
        wr(8'h24, 8'h80);
        chk(otp_busy_o, 1'b1);
        wb;
        rd(8'h2a, i_otp.ow(4'h0));
        rd(8'h24, 8'h80);
        wr(8'h24, 8'h00);
        pu(4'h8);
        wr(8'h22, 8'h04);
        wr(8'h24, 8'h40);
        chk({soft_reset_o, spi_three_wire_o}, 2'b10);
        wb;
        rd(8'h24, 8'h00);
        rd(8'h22, 8'h00);
        summarize;
    end
endmodule
bind atro_regs atro_regs_sva #(.DW(DW)) i_sva(.*);
